// [rtl/optical_out_pkg.sv]
/*
 Package for the optical serial output stage: register map, field layout, reset values,
 carrier timing constants and the packed configuration struct.
 Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
*/
// How it works
// R1 - Transmit pin is driven by the optical port only when pin select equals 00.
// R2 - Transmit invert flips the pin level; receive invert independently flips sampled receive.
// R3 - With modulation enabled and system power present, transmit is gated by 38 kHz carrier.
// R4 - In battery battery_run_mode mode no carrier modulation is applied, whatever the enable says.
// R5 - Two-bit duty select chooses carrier duty of 50, 25, 12.5 or 6.25 percent.
// R6 - Duty gives the fraction of each carrier period the transmit level is low, before transmit invert flips the pin.
// R7 - Duty select 00 gives 50 percent, ascending to 11 giving 6.25 percent.
// R8 - Power fault with battery present enters battery_run_mode mode; that condition disables modulation.
package optical_out_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // ==========================================================
   // Control field positions
   localparam int TX_SEL_LSB = 0;
   localparam int TX_INV_BIT = 2;
   localparam int RX_INV_BIT = 3;
   localparam int MOD_EN_BIT = 4;
   localparam int DUTY_LSB = 5;

   // ==========================================================
   // Status field positions
   localparam int ST_BATTERY_RUN_MODE_BIT = 0;
   localparam int ST_MOD_ACTIVE_BIT = 1;
   localparam int ST_TX_ACTIVE_BIT = 2;
   localparam int ST_RX_BIT = 3;

   // ==========================================================
   // Reset values and the active pin select
   localparam logic [1:0] TX_SEL_RESET = 2'h1;
   localparam logic [1:0] TX_SEL_ACTIVE = 2'h0;
   localparam logic [1:0] DUTY_RESET = 2'h0;

   // ==========================================================
   // Carrier timing
   localparam int CLK_HZ = 20000000;
   localparam int CARRIER_HZ = 38000;
   localparam int CARRIER_CYCLES = CLK_HZ / CARRIER_HZ;
   localparam int CNT_W = 10;

   typedef struct packed {
      logic [1:0] duty_sel;
      logic mod_en;
      logic rx_inv;
      logic tx_inv;
      logic [1:0] tx_sel;
   } ctrl_t;

endpackage

// [rtl/optical_serial_output_stage.sv]
/*
 Optical serial output stage: pin select, polarity inversion and 38 kHz carrier modulation
 of the transmit line, with an AHB-Lite slave holding control and status.
 Assumes the UART serial lines and the power flags are synchronous to hclk.
*/
`timescale 1ns/1ps
module optical_serial_output_stage #(
   parameter int CARRIER_CYCLES = optical_out_pkg::CARRIER_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic uart_txd,
   output logic uart_rxd,
   input wire logic power_fault,
   input wire logic battery_ok,
   output logic ir_tx_pin_o,
   output logic ir_tx_pin_oe,
   input wire logic ir_rx_pin
);

   localparam int W = optical_out_pkg::CNT_W;

   // ==========================================================
   // Bus slave
   optical_out_pkg::ctrl_t ctrl_r, ctrl_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic [3:0] status;
   logic access;

   assign access = hsel & hready & htrans[1];

   always_comb begin
      ctrl_nxt = ctrl_r;
      wr_pend_nxt = access & hwrite;
      addr_nxt = access ? haddr[7:0] : addr_r;
      hrdata_nxt = hrdata_r;
      if (wr_pend_r && addr_r == optical_out_pkg::CTRL_OFFSET) begin
         ctrl_nxt = hwdata[6:0];
      end
      if (access && !hwrite) begin
         if (haddr[7:0] == optical_out_pkg::CTRL_OFFSET) begin
            hrdata_nxt = {25'h0, ctrl_nxt};
         end else if (haddr[7:0] == optical_out_pkg::STATUS_OFFSET) begin
            hrdata_nxt = {28'h0, status};
         end else begin
            hrdata_nxt = 32'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= '{duty_sel: optical_out_pkg::DUTY_RESET, mod_en: 1'b0, rx_inv: 1'b0,
                     tx_inv: 1'b0, tx_sel: optical_out_pkg::TX_SEL_RESET};
         wr_pend_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata_r <= 32'h0;
      end else begin
         ctrl_r <= ctrl_nxt;
         wr_pend_r <= wr_pend_nxt;
         addr_r <= addr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ==========================================================
   // Carrier and pin drive
   logic [W-1:0] cnt_r, cnt_nxt;
   logic [W-1:0] low_cycles;
   logic battery_run_mode, mod_active, carrier_low, tx_level;
   logic tx_o_r, tx_o_nxt, tx_oe_r, tx_oe_nxt, rxd_r, rxd_nxt;

   assign battery_run_mode = power_fault & battery_ok; // R8
   assign mod_active = ctrl_r.mod_en & ~battery_run_mode; // R3 R4
   // The shift amount is widened first, or duty select 11 would wrap to a shift of zero.
   assign low_cycles = W'(CARRIER_CYCLES) >> ({1'b0, ctrl_r.duty_sel} + 3'h1); // R5 R7
   assign carrier_low = cnt_r < low_cycles; // R6
   assign status = {rxd_r, tx_oe_r, mod_active, battery_run_mode};

   always_comb begin
      cnt_nxt = (cnt_r >= W'(CARRIER_CYCLES - 1)) ? '0 : cnt_r + W'(1);
      // Modulation pulses the line low only during the UART low (space) bits.
      tx_level = mod_active ? (uart_txd | ~carrier_low) : uart_txd; // R3
      tx_o_nxt = tx_level ^ ctrl_r.tx_inv; // R2
      tx_oe_nxt = ctrl_r.tx_sel == optical_out_pkg::TX_SEL_ACTIVE; // R1
      rxd_nxt = ir_rx_pin ^ ctrl_r.rx_inv; // R2
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_r <= '0;
         tx_o_r <= 1'b1;
         tx_oe_r <= 1'b0;
         rxd_r <= 1'b1;
      end else begin
         cnt_r <= cnt_nxt;
         tx_o_r <= tx_o_nxt;
         tx_oe_r <= tx_oe_nxt;
         rxd_r <= rxd_nxt;
      end
   end

   assign ir_tx_pin_o = tx_o_r;
   assign ir_tx_pin_oe = tx_oe_r;
   assign uart_rxd = rxd_r;

endmodule

// [dv/optical_stage_props.sv]
/* Pin checker for the optical stage. Bound to its top; sees ports only. */
`timescale 1ns/1ps
module optical_stage_props #(parameter int P = 526) (
   input wire logic hclk, hresetn, hsel, hwrite, hready, uart_txd, uart_rxd, power_fault, battery_ok,
   input wire logic ir_tx_pin_o, ir_tx_pin_oe, ir_rx_pin,
   input wire logic [31:0] haddr, hwdata,
   input wire logic [1:0] htrans
);
   // ==========================================================
   // Control shadow. Long settling, so partial carrier runs are never judged.
   logic wp_r;
   logic [31:0] c_r;
   logic [10:0] run_r, st_r;
   wire md = c_r[4] & ~uart_txd & ~(power_fault & battery_ok);
   wire s = st_r > 11'h44C;
   wire k = ir_tx_pin_o ^ c_r[2];
   int lo;
   assign lo = P >> (c_r[6:5] + 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r <= 1'h0;
         c_r <= 32'h1;
         run_r <= 11'h0;
         st_r <= 11'h0;
      end else begin
         wp_r <= hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
         if (wp_r) c_r <= hwdata;
         run_r <= $changed(ir_tx_pin_o) ? 11'h1 : run_r + 11'h1;
         st_r <= (!md || wp_r) ? 11'h0 : st_r + {10'h0, st_r != 11'h7FF};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   oe_sel_a: assert property ($past(hresetn) |-> ir_tx_pin_oe == ($past(c_r[1:0]) == 2'h0))
      else $error("oe wrong");
   rx_inv_a: assert property ($past(hresetn) |-> uart_rxd == $past(ir_rx_pin ^ c_r[3]))
      else $error("rx wrong");
   tx_plain_a: assert property ($past(hresetn && !c_r[4]) |-> ir_tx_pin_o == $past(uart_txd ^ c_r[2]))
      else $error("tx wrong");
   brown_nomod_a: assert property ($past(hresetn && power_fault && battery_ok) |-> k == $past(uart_txd))
      else $error("battery_run_mode mod");
   mark_idle_a: assert property ($past(hresetn && uart_txd) |-> ir_tx_pin_o == !$past(c_r[2]))
      else $error("mark wrong");
   carrier_run_a: assert property (s && $changed(ir_tx_pin_o) |-> run_r == (k ? lo : P - lo))
      else $error("run wrong");
   low_max_a: assert property (s && !k |-> run_r <= lo)
      else $error("low long");
   high_max_a: assert property (s && k |-> run_r <= P - lo)
      else $error("high long");
endmodule

// [dv/ir_optics_model.sv]
/* Optical path: emitter light reaches the receiver. Dark: bench ambient. */
`timescale 1ns/1ps
module ir_optics_model (
   input wire logic ir_tx_pin_o,
   input wire logic ir_tx_pin_oe,
   input wire logic ambient,
   output logic ir_rx_pin
);
   assign ir_rx_pin = ir_tx_pin_oe ? ir_tx_pin_o : ambient;
endmodule

// [dv/optical_serial_output_stage_test.sv]
/* Bench: AHB-Lite master, UART line, power flags. Optics loop back. */
`timescale 1ns/1ps
module optical_serial_output_stage_test;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, uart_txd = 1'h1, power_fault = 1'h0;
   logic battery_ok = 1'h0, ambient = 1'h0, hreadyout, uart_rxd, ir_tx_pin_o, ir_tx_pin_oe, ir_rx_pin;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, n;
   logic [1:0] htrans = 2'h0;
   int n_fail = 0, total_checks = 0, cyc = 0;
   optical_serial_output_stage DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .uart_txd, .uart_rxd, .power_fault, .battery_ok,
      .ir_tx_pin_o, .ir_tx_pin_oe, .ir_rx_pin);
   ir_optics_model optics (.ir_tx_pin_o, .ir_tx_pin_oe, .ambient, .ir_rx_pin);
   initial forever #25 hclk = ~hclk;
   always @(posedge hclk) begin
      ambient <= ~ambient;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask
   task automatic lows();
      n = 32'h0;
      repeat (optical_out_pkg::CARRIER_CYCLES) @(posedge hclk) n = n + {31'h0, ~ir_tx_pin_o};
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'h1;
      bus(1'h0, 8'h00, 32'h0);
      chk(q, 32'h1);
      bus(1'h0, 8'h10, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, 8'h00, 32'hC);
      repeat (3) @(posedge hclk);
      chk({31'h0, ir_tx_pin_o}, 32'h0);
      chk({31'h0, ir_tx_pin_oe}, 32'h1);
      chk({31'h0, uart_rxd}, 32'h1);
      bus(1'h0, 8'h04, 32'h0);
      chk(q, 32'hC);
      uart_txd <= 1'h0;
      for (int d = 0; d < 4; d++) begin
         bus(1'h1, 8'h00, 32'h10 | (d << 5));
         repeat (600) @(posedge hclk);
         lows();
         chk(n, optical_out_pkg::CARRIER_CYCLES >> (d + 1));
      end
      power_fault <= 1'h1;
      battery_ok <= 1'h1;
      repeat (3) @(posedge hclk);
      lows();
      chk(n, optical_out_pkg::CARRIER_CYCLES);
      report_and_stop();
   end
endmodule
bind optical_serial_output_stage optical_stage_props #(.P(CARRIER_CYCLES)) props (.hclk, .hresetn, .hsel,
   .hwrite, .hready, .uart_txd, .uart_rxd, .power_fault, .battery_ok, .ir_tx_pin_o, .ir_tx_pin_oe,
   .ir_rx_pin, .haddr, .hwdata, .htrans);
